// *** hdl/pll_cfg_pkg.sv ***
// Shared constants and carriers for the clock-generator status and delay register bank
package pll_cfg_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_REF_CONFIG = 8'h1A;
    localparam logic [7:0] IDX_PLL_STATUS = 8'h1F;
    localparam logic [7:0] IDX_DELAY_BYPASS = 8'hA0;
    localparam logic [7:0] IDX_RAMP_CONFIG = 8'hA1;

    // Field positions
    localparam int THRESH_SEL_BIT = 6;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_FIRST_REF_BIT = 1;
    localparam int STAT_SECOND_REF_BIT = 2;
    localparam int STAT_VCO_BIT = 3;
    localparam int STAT_REFSEL_BIT = 4;
    localparam int BYPASS_BIT = 0;
    localparam int CAP_LSB = 3;
    localparam int CUR_LSB = 0;

    // Reset values
    localparam logic [7:0] REF_CONFIG_RST = 8'h00;
    localparam logic BYPASS_RST = 1'b0;
    localparam logic [2:0] CAP_CODE_RST = 3'h0;
    localparam logic [2:0] CUR_CODE_RST = 3'h0;

    // Ramp current step in microamps
    localparam logic [10:0] CUR_STEP_UA = 11'h0C8;
    // Relative full-scale constant; divisible by every current step count 1..8
    localparam logic [11:0] FULL_SCALE_K = 12'h348;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_t;

    typedef struct packed {
        logic second_reference_selected;
        logic vco_above;
        logic second_reference_input_above;
        logic first_reference_input_above;
        logic digital_lock;
    } monitor_t;

    typedef struct packed {
        logic bypass;
        logic [2:0] cap_count;
        logic [10:0] current_ua;
        logic [11:0] full_scale;
    } delay_cfg_t;

endpackage

// *** hdl/ramp_decode.sv ***
// Ramp capacitor and current decode for the output channel four fine delay
`timescale 1ns/1ps
module ramp_decode
(
    input wire logic [2:0] cap_code,
    input wire logic [2:0] cur_code,
    output logic [2:0] cap_count,
    output logic [10:0] current_ua,
    output logic [11:0] full_scale
);
    logic [3:0] steps;
    logic [14:0] product;

    always_comb
    begin
        case (cap_code) // [RULE7]
            3'h0: cap_count = 3'h4;
            3'h1: cap_count = 3'h3;
            3'h2: cap_count = 3'h3;
            3'h3: cap_count = 3'h2;
            3'h4: cap_count = 3'h3;
            3'h5: cap_count = 3'h2;
            3'h6: cap_count = 3'h2;
            default: cap_count = 3'h1;
        endcase
    end

    // Each code above zero adds one step
    assign steps = {1'b0, cur_code} + 4'h1; // [RULE10]
    assign current_ua = 11'(pll_cfg_pkg::CUR_STEP_UA * steps); // [RULE10]

    // Delay span grows with capacitance and shrinks with current
    assign product = 15'(cap_count * pll_cfg_pkg::FULL_SCALE_K);
    assign full_scale = 12'(product / steps); // [RULE8]

endmodule // ramp_decode

// *** hdl/pll_status_and_delay_cfg.sv ***
// Status and fine-delay register bank with an Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Status bit 3: oscillator above threshold
// [RULE2] Status bit 2: second reference above threshold
// [RULE3] Status bit 1: first reference above threshold
// [RULE4] Bit 6 of config 0x01A sets threshold
// [RULE5] Status bit 0: digital lock, 0 unlocked
// [RULE6] Bit 0 of 0x0A0 bypasses fine delay
// [RULE7] Capacitor field decodes to capacitor count
// [RULE8] Full scale from capacitors and current
// [RULE9] Status bit 4: selected reference
// [RULE10] Current field: 200 uA per step
// [RULE11] Status word ignores writes, follows monitors
module pll_status_and_delay_cfg
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [pll_cfg_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [pll_cfg_pkg::DATA_W-1:0] writedata,
    output logic [pll_cfg_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire pll_cfg_pkg::monitor_t monitor,
    output logic ref_threshold_select,
    output pll_cfg_pkg::delay_cfg_t delay_cfg
);
    pll_cfg_pkg::bus_state_t state_reg;
    pll_cfg_pkg::bus_state_t state_next;
    logic waitrequest_reg;
    logic [pll_cfg_pkg::DATA_W-1:0] readdata_reg;
    logic [7:0] ref_config_reg;
    logic [7:0] status_reg;
    logic bypass_reg;
    logic [2:0] cap_code_reg;
    logic [2:0] cur_code_reg;
    pll_cfg_pkg::delay_cfg_t delay_cfg_reg;
    pll_cfg_pkg::delay_cfg_t delay_cfg_next;
    logic [2:0] dec_caps;
    logic [10:0] dec_current;
    logic [11:0] dec_full_scale;
    logic [7:0] index;
    logic request;
    logic commit;
    logic lane0_write;
    logic [7:0] read_mux;
    logic srst_hold_reg;
    logic checks_off;

    assign index = address[9:2];
    assign request = read | write;
    // Request completes on the edge that sees waitrequest low
    assign commit = request && (state_reg == pll_cfg_pkg::BUS_ANSWER);
    assign lane0_write = commit && write && byteenable[0];

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pll_cfg_pkg::BUS_IDLE:
            begin
                if (request)
                begin
                    state_next = pll_cfg_pkg::BUS_ANSWER;
                end
            end
            pll_cfg_pkg::BUS_ANSWER:
            begin
                state_next = pll_cfg_pkg::BUS_IDLE;
            end
            default:
            begin
                state_next = pll_cfg_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= pll_cfg_pkg::BUS_IDLE;
            waitrequest_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            waitrequest_reg <= (state_next != pll_cfg_pkg::BUS_ANSWER);
        end
    end

    // Monitors are sampled every cycle; no software path reaches this flop
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            status_reg <= 8'h00;
        end
        else
        begin
            status_reg <= 8'h00; // [RULE11]
            status_reg[pll_cfg_pkg::STAT_VCO_BIT] <= monitor.vco_above; // [RULE1]
            status_reg[pll_cfg_pkg::STAT_SECOND_REF_BIT] <= monitor.second_reference_input_above; // [RULE2]
            status_reg[pll_cfg_pkg::STAT_FIRST_REF_BIT] <= monitor.first_reference_input_above; // [RULE3]
            status_reg[pll_cfg_pkg::STAT_LOCK_BIT] <= monitor.digital_lock; // [RULE5]
            status_reg[pll_cfg_pkg::STAT_REFSEL_BIT] <= monitor.second_reference_selected; // [RULE9]
        end
    end

    // Writable configuration; only byte lane 0 carries register bits
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ref_config_reg <= pll_cfg_pkg::REF_CONFIG_RST;
            bypass_reg <= pll_cfg_pkg::BYPASS_RST;
            cap_code_reg <= pll_cfg_pkg::CAP_CODE_RST;
            cur_code_reg <= pll_cfg_pkg::CUR_CODE_RST;
        end
        else if (lane0_write)
        begin
            case (index)
                pll_cfg_pkg::IDX_REF_CONFIG:
                begin
                    ref_config_reg <= writedata[7:0]; // [RULE4]
                end
                pll_cfg_pkg::IDX_DELAY_BYPASS:
                begin
                    bypass_reg <= writedata[pll_cfg_pkg::BYPASS_BIT]; // [RULE6]
                end
                pll_cfg_pkg::IDX_RAMP_CONFIG:
                begin
                    cap_code_reg <= writedata[pll_cfg_pkg::CAP_LSB +: 3]; // [RULE7]
                    cur_code_reg <= writedata[pll_cfg_pkg::CUR_LSB +: 3]; // [RULE10]
                end
                default:
                begin
                    ref_config_reg <= ref_config_reg;
                end
            endcase
        end
    end

    always_comb
    begin
        case (index)
            pll_cfg_pkg::IDX_REF_CONFIG: read_mux = ref_config_reg;
            pll_cfg_pkg::IDX_PLL_STATUS: read_mux = status_reg;
            pll_cfg_pkg::IDX_DELAY_BYPASS: read_mux = {7'h00, bypass_reg};
            pll_cfg_pkg::IDX_RAMP_CONFIG: read_mux = {2'h0, cap_code_reg, cur_code_reg};
            default: read_mux = 8'h00;
        endcase
    end

    // Data is latched a cycle before commit, so it stands while waitrequest is low
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            readdata_reg <= 32'h0000_0000;
        end
        else if (read && state_next == pll_cfg_pkg::BUS_ANSWER)
        begin
            readdata_reg <= {24'h000000, read_mux};
        end
    end

    ramp_decode u_ramp_decode
    (
        .cap_code(cap_code_reg),
        .cur_code(cur_code_reg),
        .cap_count(dec_caps),
        .current_ua(dec_current),
        .full_scale(dec_full_scale)
    );

    always_comb
    begin
        delay_cfg_next.bypass = bypass_reg; // [RULE6]
        delay_cfg_next.cap_count = dec_caps; // [RULE7]
        delay_cfg_next.current_ua = dec_current; // [RULE10]
        delay_cfg_next.full_scale = dec_full_scale; // [RULE8]
    end

    // Delay config outputs lag the register by one cycle to come from flops
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            delay_cfg_reg <= '0;
        end
        else
        begin
            delay_cfg_reg <= delay_cfg_next;
        end
    end

    assign readdata = readdata_reg;
    assign waitrequest = waitrequest_reg;
    assign ref_threshold_select = ref_config_reg[pll_cfg_pkg::THRESH_SEL_BIT]; // [RULE4]
    assign delay_cfg = delay_cfg_reg;

    // Registers stay cleared on the release edge itself, so checks wait one more edge
    always_ff @(posedge clock)
    begin
        srst_hold_reg <= srst;
    end

    assign checks_off = srst | srst_hold_reg;

    a_vco_flag: assert property (@(posedge clock) disable iff (checks_off) // [RULE1]
        ##1 status_reg[3] == $past(monitor.vco_above))
        else $error("vco flag does not follow monitor");
    a_second_ref_flag: assert property (@(posedge clock) disable iff (checks_off) // [RULE2]
        ##1 status_reg[2] == $past(monitor.second_reference_input_above))
        else $error("second reference flag wrong");
    a_first_ref_flag: assert property (@(posedge clock) disable iff (checks_off) // [RULE3]
        ##1 status_reg[1] == $past(monitor.first_reference_input_above))
        else $error("first reference flag wrong");
    a_thresh_write: assert property (@(posedge clock) disable iff (checks_off) // [RULE4]
        lane0_write && index == 8'h1A |=> ref_threshold_select == $past(writedata[6]))
        else $error("threshold select not taken from bit 6");
    a_lock_flag: assert property (@(posedge clock) disable iff (checks_off) // [RULE5]
        !monitor.digital_lock |=> !status_reg[0])
        else $error("lock flag high while unlocked");
    a_bypass_out: assert property (@(posedge clock) disable iff (checks_off) // [RULE6]
        lane0_write && index == 8'hA0 |=> ##1 delay_cfg.bypass == $past(writedata[0], 2))
        else $error("bypass output wrong");
    a_cap_default: assert property (@(posedge clock) disable iff (checks_off) // [RULE7]
        cap_code_reg == 3'h0 |=> delay_cfg.cap_count == 3'h4)
        else $error("default capacitor count not four");
    a_cap_two: assert property (@(posedge clock) disable iff (checks_off) // [RULE7]
        cap_code_reg == 3'h3 |=> delay_cfg.cap_count == 3'h2)
        else $error("code 011 not two capacitors");
    a_full_scale: assert property (@(posedge clock) disable iff (checks_off) // [RULE8]
        cap_code_reg == 3'h0 && cur_code_reg == 3'h7 |=> delay_cfg.full_scale == 12'h1A4)
        else $error("full scale wrong");
    a_refsel_flag: assert property (@(posedge clock) disable iff (checks_off) // [RULE9]
        ##1 status_reg[4] == $past(monitor.second_reference_selected))
        else $error("reference select flag wrong");
    a_ramp_current: assert property (@(posedge clock) disable iff (checks_off) // [RULE10]
        cur_code_reg == 3'h0 |=> delay_cfg.current_ua == 11'h0C8)
        else $error("default current not 200 uA");
    a_status_ro: assert property (@(posedge clock) disable iff (checks_off) // [RULE11]
        ##1 status_reg[7:5] == 3'h0 && $stable(monitor) |=> $stable(status_reg))
        else $error("status changed without monitor change");
    a_wait_bound: assert property (@(posedge clock) disable iff (checks_off)
        request && waitrequest |=> !waitrequest)
        else $error("no answer within one wait cycle");

    c_status_read: cover property (@(posedge clock) disable iff (checks_off)
        commit && read && index == 8'h1F);
    c_ramp_write: cover property (@(posedge clock) disable iff (checks_off)
        lane0_write && index == 8'hA1);
    c_lock_gain: cover property (@(posedge clock) disable iff (checks_off)
        $rose(status_reg[0]));

endmodule // pll_status_and_delay_cfg

// *** test/pll_status_and_delay_cfg_test.sv ***
// Self-checking bench for the status and fine-delay register bank
`timescale 1ns/1ps
module pll_status_and_delay_cfg_test;
    typedef struct packed {
        logic [2:0] cap_code;
        logic [2:0] cur_code;
        logic [2:0] caps;
    } row_t;
    logic clock;
    logic srst;
    logic [9:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    pll_cfg_pkg::monitor_t monitor;
    logic ref_threshold_select;
    pll_cfg_pkg::delay_cfg_t delay_cfg;
    pll_cfg_pkg::delay_cfg_t exp_cfg;
    row_t rows [8];
    int err_count;
    int tests_run;
    logic [31:0] rd;

    pll_status_and_delay_cfg dut_u (
        .clock(clock),
        .srst(srst),
        .address(address),
        .read(read),
        .write(write),
        .byteenable(byteenable),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .monitor(monitor),
        .ref_threshold_select(ref_threshold_select),
        .delay_cfg(delay_cfg)
    );

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cfg(input pll_cfg_pkg::delay_cfg_t got, input pll_cfg_pkg::delay_cfg_t exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected delay config at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; holds the request until waitrequest is seen low
    task automatic bus_xfer(input logic wr, input logic [9:0] addr, input logic [31:0] data,
                            input logic [3:0] be, output logic [31:0] rdata);
        int n;
        n = 0;
        address <= addr;
        writedata <= data;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
        begin
            err_count++;
            $display("unexpected hang at %0t: waitrequest %h expected %h", $time, waitrequest, 1'b0);
        end
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // One idle edge so the strobes never get two assignments in one step
        @(posedge clock);
    endtask

    function automatic pll_cfg_pkg::delay_cfg_t expect_cfg(input logic byp, input logic [2:0] caps,
                                                           input logic [2:0] cur);
        pll_cfg_pkg::delay_cfg_t e;
        e.bypass = byp;
        e.cap_count = caps;
        e.current_ua = 11'(int'(pll_cfg_pkg::CUR_STEP_UA) * (int'(cur) + 1));
        e.full_scale = 12'((int'(pll_cfg_pkg::FULL_SCALE_K) * int'(caps)) / (int'(cur) + 1));
        return e;
    endfunction

    initial
    begin
        #(25 * 4000);
        err_count++;
        $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        report_and_stop();
    end

    initial
    begin
        err_count = 0;
        tests_run = 0;
        srst = 1'b1;
        address = 10'h000;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'hF;
        writedata = 32'h0000_0000;
        monitor = 5'h00;
        rows = '{'{3'h0, 3'h7, 3'h4}, '{3'h1, 3'h0, 3'h3}, '{3'h2, 3'h3, 3'h3},
                 '{3'h3, 3'h1, 3'h2}, '{3'h4, 3'h6, 3'h3}, '{3'h5, 3'h2, 3'h2},
                 '{3'h6, 3'h5, 3'h2}, '{3'h7, 3'h4, 3'h1}};
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 8; i++)
        begin
            bus_xfer(1'b1, 10'h280, 32'(rows[i].cur_code[0]), 4'hF, rd);
            bus_xfer(1'b1, 10'h284, 32'({rows[i].cap_code, rows[i].cur_code}), 4'hF, rd);
            bus_xfer(1'b0, 10'h284, 32'h0, 4'hF, rd);
            check_word(rd, 32'({rows[i].cap_code, rows[i].cur_code}));
            bus_xfer(1'b0, 10'h280, 32'h0, 4'hF, rd);
            check_word(rd, 32'(rows[i].cur_code[0]));
            exp_cfg = expect_cfg(rows[i].cur_code[0], rows[i].caps, rows[i].cur_code);
            check_cfg(delay_cfg, exp_cfg);
        end
        $display("Test ramp decode rows done");
        for (int k = 0; k < 6; k++)
        begin
            monitor <= (k == 5) ? 5'h1F : 5'(5'h01 << k);
            @(posedge clock);
            bus_xfer(1'b0, 10'h07C, 32'h0, 4'hF, rd);
            check_word(rd, (k == 5) ? 32'h1F : 32'(5'h01 << k));
        end
        // Software write must not disturb the flags
        bus_xfer(1'b1, 10'h07C, 32'h0000_00E0, 4'hF, rd);
        monitor <= 5'h0A;
        @(posedge clock);
        bus_xfer(1'b0, 10'h07C, 32'h0, 4'hF, rd);
        check_word(rd, 32'h0000_000A);
        $display("Test status flags done");
        bus_xfer(1'b1, 10'h068, 32'h0000_0040, 4'hF, rd);
        @(posedge clock);
        check_word(32'(ref_threshold_select), 32'h1);
        bus_xfer(1'b1, 10'h068, 32'h0000_0000, 4'hE, rd);
        check_word(32'(ref_threshold_select), 32'h1);
        bus_xfer(1'b0, 10'h068, 32'h0, 4'hF, rd);
        check_word(rd, 32'h0000_0040);
        bus_xfer(1'b1, 10'h068, 32'h0000_0000, 4'hF, rd);
        @(posedge clock);
        check_word(32'(ref_threshold_select), 32'h0);
        bus_xfer(1'b0, 10'h3FC, 32'h0, 4'hF, rd);
        check_word(rd, 32'h0000_0000);
        $display("Test threshold and unmapped done");
        bus_xfer(1'b1, 10'h284, 32'h0000_003F, 4'hF, rd);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        exp_cfg = expect_cfg(1'b0, 3'h4, 3'h0);
        check_cfg(delay_cfg, exp_cfg);
        bus_xfer(1'b0, 10'h284, 32'h0, 4'hF, rd);
        check_word(rd, 32'h0000_0000);
        $display("Test second reset done");
        report_and_stop();
    end
endmodule // pll_status_and_delay_cfg_test
